// [logic/csg_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "csg_defines.svh"

// ==========================================================
// Output FIFO
module csg_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of 2");
  end
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } csg_fst_t;
  csg_fst_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;
  assign push = in_valid && s_q.rdy;
  assign pop = s_q.cnt != '0 && out_ready;
  assign in_ready = s_q.rdy;
  assign out_valid = s_q.cnt != '0;
  assign out_data = mem_q[s_q.rp];
  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop) s_d.rp = s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    s_d.rdy = s_d.cnt != DEPTH[AW:0];
  end
  // State and storage registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
    end else if (ce) begin
      s_q <= s_d;
      if (push) mem_q[s_q.wp] <= in_data;
    end
  end
endmodule

// ==========================================================
// Chroma shaping and gain
module csg_top import csg_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h21, // Arbitrary bus address
  parameter logic [9:0] LUMA_TARGET = 10'h300,
  parameter logic [9:0] BURST_TARGET = 10'h080
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // 2-wire register port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Sample input
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [9:0] luma_in,
  input wire logic [9:0] chroma_in,
  input wire logic fmt_composite,
  input wire logic std_is_pal,
  input wire logic active_video,
  input wire logic line_start,
  input wire logic field_start,
  input wire logic [9:0] burst_amp,
  // Sample output
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] luma_out,
  output logic [9:0] chroma_out
);
  typedef struct packed {
    csg_i2c_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic scl_p;
    logic sda_p;
    logic oe;
    logic got;
    logic [7:0] r_shape;
    logic [7:0] r_upd;
    logic [7:0] r_mode;
    logic [7:0] r_cg_hi;
    logic [7:0] r_cg_lo;
    logic [7:0] r_lg_hi;
    logic [7:0] r_lg_lo;
    logic [1:0] dn;
    logic [11:0] acc;
    logic [9:0] y1;
    logic v1;
    logic [15:0] shp;
    logic [9:0] y2;
    logic [9:0] c2;
    logic v2;
    logic [9:0] cprev;
    logic [11:0] lgain;
    logic [11:0] cgain;
    logic [9:0] pk;
    logic ovr;
    logic pw_act;
    logic [9:0] y3;
    logic [9:0] c3;
    logic v3;
  } csg_st_t;
  csg_st_t s_q, s_d;
  logic f_rdy;
  logic adv;
  logic tick;
  logic scl_r, scl_f, start, stop;

  // Shaping coefficient: bigger shift is narrower
  function automatic logic [2:0] shape_shift(input logic [2:0] m,
                                             input logic pal);
    logic [2:0] k;
    k = 3'd0;
    case (m)
      3'd0: k = pal ? 3'd3 : 3'd4;
      3'd1: k = pal ? 3'd2 : 3'd3;
      3'd7: k = 3'd0;
      default: k = 3'd7 - m;
    endcase
    return k;
  endfunction

  // Gain multiply with saturation
  function automatic logic [9:0] apply_gain(input logic [9:0] x,
                                            input logic [11:0] g);
    logic [21:0] p;
    p = x * g;
    return (p[21:20] != 2'b00) ? `CSG_SAMP_MAX : p[19:10];
  endfunction

  // Step the gain toward its target, held where a step would pass a limit
  function automatic logic [11:0] track(input logic [11:0] g,
                                        input logic [9:0] meas,
                                        input logic [9:0] tgt,
                                        input logic [11:0] stp);
    logic [11:0] n;
    n = g;
    if (meas < tgt && g <= `CSG_GAIN_MAX - stp) n = g + stp;
    if (meas > tgt && g >= `CSG_GAIN_MIN + stp) n = g - stp;
    return n;
  endfunction

  function automatic logic [7:0] reg_read(input csg_st_t s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == `CSG_REG_SHAPE) d = s.r_shape;
    else if (a == `CSG_REG_UPD) d = s.r_upd;
    else if (a == `CSG_REG_MODE) d = s.r_mode;
    else if (a == `CSG_REG_CG_HI) d = {s.r_cg_hi[7:4], s.cgain[11:8]};
    else if (a == `CSG_REG_CG_LO) d = s.cgain[7:0];
    else if (a == `CSG_REG_LG_HI) d = {s.r_lg_hi[7:4], s.lgain[11:8]};
    else if (a == `CSG_REG_LG_LO) d = s.lgain[7:0];
    return d;
  endfunction

  assign scl_r = scl_in && !s_q.scl_p;
  assign scl_f = !scl_in && s_q.scl_p;
  assign start = scl_in && s_q.scl_p && s_q.sda_p && !sda_in;
  assign stop = scl_in && s_q.scl_p && !s_q.sda_p && sda_in;
  assign adv = samp_valid && f_rdy;
  assign tick = s_q.r_upd[0] ? field_start : line_start;

  // Next state
  always_comb begin
    logic [11:0] stp;
    logic [9:0] err;
    logic [2:0] k;
    logic [15:0] xin;
    logic [11:0] mg;
    logic [7:0] rdv;
    stp = `CSG_STEP_SLOW;
    err = 10'h000;
    k = 3'd0;
    xin = 16'h0000;
    mg = 12'h000;
    rdv = reg_read(s_q, s_q.ptr);
    s_d = s_q;
    s_d.scl_p = scl_in;
    s_d.sda_p = sda_in;
    // Serial register port
    if (start) begin
      s_d.st = CSG_I_ADDR;
      s_d.cnt = 3'd0;
      s_d.got = 1'b0;
      s_d.oe = 1'b0;
    end else if (stop) begin
      s_d.st = CSG_I_IDLE;
      s_d.oe = 1'b0;
    end else if (scl_r) begin
      case (s_q.st)
        CSG_I_ADDR, CSG_I_SUB, CSG_I_WR: begin
          s_d.sh = {s_q.sh[6:0], sda_in};
          s_d.cnt = s_q.cnt + 3'd1;
          if (s_q.st == CSG_I_ADDR) s_d.got = 1'b1;
        end
        CSG_I_RD: s_d.cnt = s_q.cnt + 3'd1;
        // Master NACK ends the read; ACK waits for the fall
        CSG_I_RACK: if (sda_in) s_d.st = CSG_I_IDLE;
        default: ;
      endcase
    end else if (scl_f) begin
      case (s_q.st)
        CSG_I_ADDR: begin
          // The fall just after START carries no address yet
          if (s_q.cnt == 3'd0 && s_q.got) begin
            if (s_q.sh[7:1] == DEV_ADDR) begin
              s_d.st = CSG_I_ACKA;
              s_d.oe = 1'b1;
            end else begin
              s_d.st = CSG_I_IDLE;
            end
          end
        end
        CSG_I_ACKA: begin
          if (s_q.sh[0]) begin
            s_d.st = CSG_I_RD;
            s_d.sh = rdv;
            s_d.oe = !rdv[7];
          end else begin
            s_d.st = CSG_I_SUB;
            s_d.oe = 1'b0;
          end
        end
        CSG_I_SUB: begin
          if (s_q.cnt == 3'd0) begin
            s_d.ptr = s_q.sh;
            s_d.st = CSG_I_ACKS;
            s_d.oe = 1'b1;
          end
        end
        CSG_I_WR: begin
          if (s_q.cnt == 3'd0) begin
            s_d.st = CSG_I_ACKW;
            s_d.oe = 1'b1;
            if (s_q.ptr == `CSG_REG_SHAPE) s_d.r_shape = s_q.sh;
            else if (s_q.ptr == `CSG_REG_UPD) s_d.r_upd = s_q.sh;
            else if (s_q.ptr == `CSG_REG_MODE) s_d.r_mode = s_q.sh;
            else if (s_q.ptr == `CSG_REG_CG_HI) s_d.r_cg_hi = s_q.sh;
            else if (s_q.ptr == `CSG_REG_CG_LO) s_d.r_cg_lo = s_q.sh;
            else if (s_q.ptr == `CSG_REG_LG_HI) s_d.r_lg_hi = s_q.sh;
            else if (s_q.ptr == `CSG_REG_LG_LO) s_d.r_lg_lo = s_q.sh;
          end
        end
        CSG_I_ACKS, CSG_I_ACKW: begin
          s_d.st = CSG_I_WR;
          s_d.oe = 1'b0;
          if (s_q.st == CSG_I_ACKW) s_d.ptr = s_q.ptr + 8'd1;
        end
        CSG_I_RD: begin
          if (s_q.cnt == 3'd0) begin
            s_d.st = CSG_I_RACK;
            s_d.oe = 1'b0;
            s_d.ptr = s_q.ptr + 8'd1;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.oe = !s_q.sh[6];
          end
        end
        CSG_I_RACK: begin
          s_d.st = CSG_I_RD;
          s_d.oe = !rdv[7];
        end
        default: ;
      endcase
      if (s_q.st == CSG_I_RACK) begin
        s_d.sh = reg_read(s_q, s_q.ptr);
      end
    end
    if (s_q.st == CSG_I_RD && s_d.st == CSG_I_RD && scl_f && s_q.cnt == 3'd0
        && s_q.oe == 1'b0 && s_d.cnt == 3'd0) begin
      s_d.oe = !s_q.sh[7];
    end
    // Decimator: chroma is the average of 4 or 2 oversampled values, luma is the last one
    if (adv) begin
      s_d.v1 = 1'b0;
      s_d.acc = s_q.acc + {2'b00, chroma_in};
      s_d.dn = s_q.dn + 2'd1;
      if (s_q.dn == (fmt_composite ? 2'd3 : 2'd1)) begin
        s_d.y1 = luma_in;
        s_d.v1 = 1'b1;
        s_d.dn = 2'd0;
        xin = fmt_composite ? {s_d.acc, 4'h0} >> 2 : {s_d.acc, 4'h0} >> 1;
        s_d.shp = {xin[13:4], 6'h00};
        s_d.acc = 12'h000;
      end else begin
        s_d.shp = s_q.shp;
      end
      // Shaping low-pass, one-pole with selectable bandwidth
      k = shape_shift(s_q.r_shape[7:5], std_is_pal);
      s_d.v2 = s_q.v1;
      s_d.y2 = s_q.y1;
      if (s_q.v1) begin
        xin = {s_q.c2, 6'h00};
        s_d.c2 = 10'((xin + ((s_q.shp - xin) >> k)) >> 6);
        if (s_q.shp < xin) begin
          s_d.c2 = 10'((xin - ((xin - s_q.shp) >> k)) >> 6);
        end
      end
      // Resampler: response fixed by input format
      if (s_q.v2) s_d.cprev = s_q.c2;
      // Gain stage
      s_d.v3 = s_q.v2;
      if (s_q.v2) begin
        s_d.y3 = apply_gain(s_q.y2, s_q.lgain);
        err = fmt_composite ? 10'((11'(s_q.c2) + 11'(s_q.cprev)) >> 1)
                            : s_q.c2;
        if (err >= `CSG_MID) begin
          s_d.c3 = `CSG_MID + (apply_gain(err - `CSG_MID, s_q.cgain) >> 1);
        end else begin
          s_d.c3 = `CSG_MID - (apply_gain(`CSG_MID - err, s_q.cgain) >> 1);
        end
      end
    end
    // Active video measurement
    if (adv && active_video) begin
      if (luma_in > s_q.pk) s_d.pk = luma_in;
      if (luma_in == `CSG_SAMP_MAX) s_d.ovr = 1'b1;
    end
    // Luma gain loop
    mg = {s_q.r_lg_hi[3:0], s_q.r_lg_lo};
    err = (s_q.pk > LUMA_TARGET) ? s_q.pk - LUMA_TARGET : LUMA_TARGET - s_q.pk;
    case (s_q.r_mode[7:6])
      default: stp = `CSG_STEP_SLOW;
    endcase
    case (s_q.r_lg_hi[7:6])
      2'b00: stp = `CSG_STEP_SLOW;
      2'b01: stp = `CSG_STEP_MED;
      2'b10: stp = `CSG_STEP_FAST;
      default: stp = (err > `CSG_ADAPT_ERR) ? `CSG_STEP_FAST : `CSG_STEP_SLOW;
    endcase
    case (csg_lmode_t'(s_q.r_mode[6:4]))
      CSG_L_MAN: begin
        s_d.lgain = mg;
        s_d.pw_act = 1'b0;
      end
      CSG_L_AUTO, CSG_L_PW: begin
        if (tick) begin
          s_d.pk = 10'h000;
          s_d.ovr = 1'b0;
          if (s_q.r_mode[5] && s_q.ovr) begin
            s_d.pw_act = 1'b1;
            s_d.lgain = (s_q.lgain >= `CSG_GAIN_MIN + `CSG_STEP_PW) ?
                        s_q.lgain - `CSG_STEP_PW : `CSG_GAIN_MIN;
          end else begin
            s_d.pw_act = 1'b0;
            s_d.lgain = track(s_q.lgain, s_q.pk, LUMA_TARGET, stp);
          end
        end
      end
      default: s_d.lgain = s_q.lgain;
    endcase
    // Chroma gain loop
    case (csg_cmode_t'(s_q.r_mode[1:0]))
      CSG_C_MAN: s_d.cgain = {s_q.r_cg_hi[3:0], s_q.r_cg_lo};
      CSG_C_LUMA: s_d.cgain = s_q.lgain;
      CSG_C_AUTO: begin
        if (tick) s_d.cgain = track(s_q.cgain, burst_amp, BURST_TARGET,
                                    `CSG_STEP_SLOW);
      end
      default: s_d.cgain = s_q.cgain;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= CSG_I_IDLE;
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
      s_q.r_shape <= `CSG_RST_SHAPE;
      s_q.r_upd <= `CSG_RST_UPD;
      s_q.r_mode <= `CSG_RST_MODE;
      s_q.r_cg_hi <= `CSG_RST_CG_HI;
      s_q.r_cg_lo <= `CSG_RST_CG_LO;
      s_q.r_lg_hi <= `CSG_RST_LG_HI;
      s_q.r_lg_lo <= `CSG_RST_LG_LO;
      s_q.lgain <= `CSG_GAIN_MIN;
      s_q.cgain <= `CSG_GAIN_MIN;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s_q.oe;
  assign samp_ready = f_rdy;

  // Output buffer, stalls the whole sample chain when full
  csg_fifo #(.WIDTH(20), .DEPTH(4)) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(adv && s_q.v3),
    .in_ready(f_rdy),
    .in_data({s_q.y3, s_q.c3}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({luma_out, chroma_out})
  );
endmodule
`default_nettype wire

// [common/csg_defines.svh]
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH
// ==========================================================
// Register offsets
`define CSG_REG_SHAPE 8'h17
`define CSG_REG_UPD 8'h2b
`define CSG_REG_MODE 8'h2c
`define CSG_REG_CG_HI 8'h2d
`define CSG_REG_CG_LO 8'h2e
`define CSG_REG_LG_HI 8'h2f
`define CSG_REG_LG_LO 8'h30
// ==========================================================
// Reset values
`define CSG_RST_SHAPE 8'h01
`define CSG_RST_UPD 8'h41
`define CSG_RST_MODE 8'h22
`define CSG_RST_CG_HI 8'hc4
`define CSG_RST_CG_LO 8'h00
`define CSG_RST_LG_HI 8'hc4
`define CSG_RST_LG_LO 8'h00
// ==========================================================
// Gain and loop constants
`define CSG_GAIN_MIN 12'h400
`define CSG_GAIN_MAX 12'hfff
`define CSG_STEP_SLOW 12'h001
`define CSG_STEP_MED 12'h002
`define CSG_STEP_FAST 12'h00a
`define CSG_STEP_PW 12'h010
`define CSG_ADAPT_ERR 10'h040
`define CSG_SAMP_MAX 10'h3ff
`define CSG_MID 10'h200
`endif

// [common/csg_pkg.sv]
package csg_pkg;
  // ==========================================================
  // Serial port states, Gray along the write path
  typedef enum logic [3:0] {
    CSG_I_IDLE = 4'h0,
    CSG_I_ADDR = 4'h1,
    CSG_I_ACKA = 4'h3,
    CSG_I_SUB = 4'h2,
    CSG_I_ACKS = 4'h6,
    CSG_I_WR = 4'h7,
    CSG_I_ACKW = 4'h5,
    CSG_I_RD = 4'h4,
    CSG_I_RACK = 4'hc
  } csg_i2c_t;
  typedef enum logic [2:0] {
    CSG_L_MAN = 3'h0, CSG_L_AUTO = 3'h1, CSG_L_PW = 3'h2, CSG_L_FRZ = 3'h7
  } csg_lmode_t;
  typedef enum logic [1:0] {
    CSG_C_MAN = 2'h0, CSG_C_LUMA = 2'h1, CSG_C_AUTO = 2'h2, CSG_C_FRZ = 2'h3
  } csg_cmode_t;
endpackage

// [dv/csg_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port checker
module csg_chk (
  // Clocking
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Register port
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Stream
  input wire logic samp_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [9:0] luma_out
);
  // One clock domain for all checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  property p_rst_idle;
    $fell(sys_rst) |-> !out_valid && samp_ready && !sda_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs busy after reset");
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pin driven high");
  property p_oe_rise;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data pulled while clock high");
  property p_oe_hold;
    sda_oe && scl_in |=> sda_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data released while clock high");
  property p_hold_out;
    out_valid && !out_ready |=> out_valid && $stable(luma_out);
  endproperty
  a_hold_out: assert property (p_hold_out)
    else $error("output changed while stalled");
  property p_empty_ready;
    !out_valid |-> samp_ready;
  endproperty
  a_empty_ready: assert property (p_empty_ready)
    else $error("input refused with buffer empty");
  property p_fell_valid;
    $fell(out_valid) |-> $past(out_ready);
  endproperty
  a_fell_valid: assert property (p_fell_valid)
    else $error("output lost without drain");
  property p_ce_freeze;
    !ce |=> $stable(out_valid) && $stable(samp_ready) && $stable(sda_oe);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved with enable low");
endmodule

bind csg_top csg_chk u_chk (.ref_clk, .sys_rst, .ce, .scl_in, .sda_out,
  .sda_oe, .samp_ready, .out_valid, .out_ready, .luma_out);
`default_nettype wire

// [dv/csg_src.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Digitized video source
module csg_src (
  // Clocking
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic [9:0] level,
  // Samples
  output logic samp_valid,
  input wire logic samp_ready,
  output logic [9:0] luma_in,
  output logic [9:0] chroma_in,
  output logic active_video,
  output logic line_start,
  output logic field_start,
  output logic [9:0] burst_amp
);
  logic [7:0] pos = 8'h00;
  // Offer held until taken; idle data is inverted so it is never reused
  always @(posedge ref_clk) begin
    line_start <= 1'b0;
    field_start <= 1'b0;
    burst_amp <= 10'h080;
    if (sys_rst) begin
      samp_valid <= 1'b0;
      pos <= 8'h00;
    end else if (!samp_valid || samp_ready) begin
      samp_valid <= run;
      luma_in <= run ? level : ~level;
      chroma_in <= run ? 10'h200 : 10'h1ff;
      active_video <= pos[4:3] != 2'h0;
      if (samp_valid) begin
        pos <= pos + 8'h01;
        line_start <= pos[4:0] == 5'h1f;
        field_start <= pos == 8'hff;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Register and stream regression
module tb_top;
  localparam logic [6:0] ADDR = 7'h21; // Arbitrary bus address
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic scl = 1'b1;
  logic sda_drv = 1'b1;
  logic fmt = 1'b1;
  logic out_ready = 1'b1;
  logic run = 1'b0;
  logic [9:0] level = 10'h100;
  wire logic sda_in;
  logic sda_out, sda_oe, samp_valid, samp_ready, active_video;
  logic line_start, field_start, out_valid;
  logic [9:0] luma_in, chroma_in, burst_amp, luma_out, chroma_out, last_l;
  logic [9:0] last_c;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_in = 0;
  int n_out = 0;
  logic [7:0] ra [7] = '{8'h17, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30};
  logic [7:0] rv [7] = '{8'h01, 8'h41, 8'h22, 8'hc4, 8'h00, 8'hc4, 8'h00};
  // Open-drain data wire
  assign sda_in = sda_drv & (~sda_oe | sda_out);
  csg_top #(.DEV_ADDR(ADDR)) dut (.ref_clk, .sys_rst, .ce, .scl_in(scl),
    .sda_in, .sda_out, .sda_oe, .samp_valid, .samp_ready, .luma_in,
    .chroma_in, .fmt_composite(fmt), .std_is_pal(1'b0), .active_video,
    .line_start, .field_start, .burst_amp, .out_valid, .out_ready,
    .luma_out, .chroma_out);
  csg_src u_src (.ref_clk, .sys_rst, .run, .level, .samp_valid,
    .samp_ready, .luma_in, .chroma_in, .active_video, .line_start,
    .field_start, .burst_amp);
  // Clock
  initial forever #20 ref_clk = ~ref_clk;
  // Cycle ceiling and stream tallies
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (samp_valid && samp_ready) n_in <= n_in + 1;
    if (out_valid && out_ready) n_out <= n_out + 1;
    if (out_valid && out_ready) last_l <= luma_out;
    if (out_valid && out_ready) last_c <= chroma_out;
    if (cyc == 90000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Serial port: one line phase lasts four cycles
  task automatic ph(input logic s, input logic d);
    @(posedge ref_clk);
    scl <= s;
    sda_drv <= d;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic bit_io(input logic d, output logic q);
    ph(1'b0, d);
    ph(1'b1, d);
    q = sda_in;
    ph(1'b0, d);
  endtask
  task automatic go();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  task automatic halt();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(b[i], q);
    bit_io(1'b1, ack);
  endtask
  task automatic rxb(input logic nack, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    go();
    tx({ADDR, 1'b0}, k);
    tx(a, k);
    tx(d, k);
    halt();
  endtask
  // Two-byte read from a register offset onward
  task automatic rd2(input logic [7:0] a, output logic [11:0] g);
    logic [7:0] h, l;
    logic k;
    go();
    tx({ADDR, 1'b0}, k);
    tx(a, k);
    halt();
    go();
    tx({ADDR, 1'b1}, k);
    rxb(1'b0, h);
    rxb(1'b1, l);
    halt();
    g = {h[3:0], l};
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [11:0] g;
    logic [7:0] h, l;
    logic k;
    go();
    tx({ADDR, 1'b0}, k);
    tx(a, k);
    halt();
    go();
    tx({ADDR, 1'b1}, k);
    rxb(1'b1, h);
    halt();
    chk({4'h0, h}, {4'h0, e});
  endtask
  // Counts outputs over n accepted samples of steady flow
  task automatic win(input int n, input int e);
    int a0, o0, t;
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    a0 = n_in;
    o0 = n_out;
    t = 0;
    while (n_in - a0 < n && t < 500) begin
      @(negedge ref_clk);
      t++;
    end
    chk(12'(n_out - o0), 12'(e));
  endtask
  // Main sequence
  initial begin : main
    logic [11:0] g, g2;
    logic k;
    int t;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rdc(ra[i], rv[i]);
    go();
    tx({ADDR ^ 7'h01, 1'b0}, k);
    halt();
    chk(12'(k), 12'h001);
    wr(8'h40, 8'h5a);
    rdc(8'h40, 8'h00);
    for (int v = 0; v < 8; v++) begin
      wr(8'h17, {3'(v), 5'h01});
      rdc(8'h17, {3'(v), 5'h01});
    end
    wr(8'h2c, 8'h00);
    run <= 1'b1;
    win(40, 10);
    chk({2'h0, last_l}, 12'h100);
    chk({2'h0, last_c}, 12'h200);
    wr(8'h2f, 8'hc6);
    wr(8'h30, 8'h00);
    win(40, 10);
    chk({2'h0, last_l}, 12'h180);
    rd2(8'h2f, g);
    chk(g, 12'h600);
    wr(8'h2c, 8'h70);
    wr(8'h30, 8'h55);
    rd2(8'h2f, g);
    chk(g, 12'h600);
    wr(8'h2c, 8'h00);
    rd2(8'h2f, g);
    chk(g, 12'h655);
    wr(8'h2c, 8'h01);
    rd2(8'h2d, g);
    chk(g, 12'h655);
    wr(8'h2c, 8'h00);
    rd2(8'h2d, g);
    chk(g, 12'h400);
    fmt <= 1'b0;
    win(40, 20);
    fmt <= 1'b1;
    wr(8'h2b, 8'h40);
    wr(8'h2c, 8'h10);
    repeat (3000) @(posedge ref_clk);
    rd2(8'h2f, g);
    chk(12'(g > 12'h655), 12'h001);
    level <= 10'h3ff;
    wr(8'h2c, 8'h20);
    repeat (2000) @(posedge ref_clk);
    rd2(8'h2f, g2);
    chk(12'(g2 < g), 12'h001);
    wr(8'h2c, 8'h70);
    rd2(8'h2f, g);
    repeat (500) @(posedge ref_clk);
    rd2(8'h2f, g2);
    chk(g2, g);
    out_ready <= 1'b0;
    t = 0;
    while (samp_ready !== 1'b0 && t < 300) begin
      @(posedge ref_clk);
      t++;
    end
    chk(12'(samp_ready), 12'h000);
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    out_ready <= 1'b1;
    run <= 1'b0;
    repeat (100) @(posedge ref_clk);
    chk(12'(out_valid), 12'h000);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(8'h2c, 8'h22);
    summarize();
  end
endmodule
`default_nettype wire
